// *** rtl/bmc_monitor.sv ***
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
module bmc_monitor
  import bmc_pkg::*;
#(
  parameter int FAST_SAMPLE_CYCLES = FAST_SAMPLE_CYCLES_DEF,
  parameter int SLOW_SAMPLE_CYCLES = SLOW_SAMPLE_CYCLES_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Fuses and analog side
  input  wire bmc_fuse_t         detector_config_fuse,
  input  wire logic              low_power_req,
  input  wire logic              warn_comp_below,
  input  wire logic              detector_ready,
  // Control outputs
  output bmc_mode_t              detector_mode,
  output logic                   detector_enable,
  output logic                   detector_sample,
  output logic                   early_warning_monitor_enable,
  output logic [2:0]             threshold_code,
  output logic [1:0]             warning_offset_code,
  output logic                   sample_rate_sel,
  output logic                   wake_hold,
  output logic                   irq
);

  bmc_fuse_t      fuse_sync;
  logic           below_sync;
  logic           ready_sync;
  bmc_mode_ctrl_t mode_ctrl;
  logic [2:0]     thr_code;
  logic [1:0]     ofs_code;
  bmc_irq_ctrl_t  irq_ctrl;
  logic           warning_irq_flag;
  logic           below_warning_status;
  logic [2:0]     guard_left;
  logic           guard_open;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic           wr_fire;
  logic           rd_fire;
  logic [3:0]     wr_idx;
  logic           wr_lane;
  logic           wr_mapped;
  logic [3:0]     rd_idx;
  logic           rd_mapped;
  logic [7:0]     rd_byte;
  logic [7:0]     wr_byte;
  bmc_mode_t      next_mode;
  logic           det_on;
  logic           det_sampled;
  logic           tick;
  logic           take_sample;
  logic           monitor_on;
  logic           cross_fall;
  logic           cross_rise;
  logic           warn_event;
  logic           flag_clear;

  // Pins crossing into the clock domain
  bmc_sync #(
    .WIDTH ($bits(bmc_fuse_t) + 2)
  ) u_sync (
    .aclk (aclk),
    .d    ({detector_config_fuse, warn_comp_below, detector_ready}),
    .q    ({fuse_sync, below_sync, ready_sync})
  );

  // Sleep picks the low-power field, wake the active field
  always_comb begin
    if (low_power_req) begin
      next_mode = (mode_ctrl.sleep_mode == SLEEP_RESERVED) ? MODE_OFF
                                                            : bmc_mode_t'(mode_ctrl.sleep_mode);
    end else begin
      next_mode = bmc_mode_t'(mode_ctrl.active_mode);
    end
  end

  assign det_on      = (detector_mode != MODE_OFF);
  assign det_sampled = (detector_mode == MODE_SAMPLED);

  bmc_sample_ticker #(
    .FAST_CYCLES (FAST_SAMPLE_CYCLES),
    .SLOW_CYCLES (SLOW_SAMPLE_CYCLES)
  ) u_ticker (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (det_sampled),
    .slow    (mode_ctrl.sample_rate_sel),
    .tick    (tick)
  );

  // Monitor only runs with the detector, sampled with it
  assign take_sample = det_on && (!det_sampled || tick);
  assign monitor_on  = det_on && irq_ctrl.warning_irq_enable;

  assign cross_fall = !below_warning_status && below_sync;
  assign cross_rise = below_warning_status && !below_sync;

  always_comb begin
    case (bmc_dir_t'(irq_ctrl.warning_direction_sel))
      DIR_FALL: warn_event = cross_fall;
      DIR_RISE: warn_event = cross_rise;
      DIR_BOTH: warn_event = cross_fall || cross_rise;
      default:  warn_event = 1'b0;
    endcase
  end

  // Bus decode
  assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign wr_idx    = aw_addr[IDX_MSB:IDX_LSB];
  assign wr_byte   = w_data[7:0];
  assign wr_lane   = wr_fire && w_strb[0];
  assign wr_mapped = (aw_addr[ADDR_W-1:PAGE_LSB] == '0) && (wr_idx <= IDX_GUARD);
  assign rd_idx    = s_axi_araddr[IDX_MSB:IDX_LSB];
  assign rd_mapped = (s_axi_araddr[ADDR_W-1:PAGE_LSB] == '0) && (rd_idx <= IDX_GUARD);
  assign guard_open = (guard_left != '0);
  assign flag_clear = wr_lane && wr_mapped && (wr_idx == IDX_WARN_FLAGS) && wr_byte[0];

  always_comb begin
    case (rd_idx)
      IDX_MODE_CTRL:     rd_byte = mode_ctrl;
      IDX_THRESHOLD:     rd_byte = {5'h00, thr_code};
      IDX_WARN_LEVEL:    rd_byte = {6'h00, ofs_code};
      IDX_WARN_IRQ_CTRL: rd_byte = irq_ctrl;
      IDX_WARN_FLAGS:    rd_byte = {7'h00, warning_irq_flag};
      IDX_WARN_STATUS:   rd_byte = {7'h00, below_warning_status};
      IDX_GUARD:         rd_byte = {7'h00, guard_open};
      default:           rd_byte = REG_RESET;
    endcase
    if (!rd_mapped) begin
      rd_byte = REG_RESET;
    end
  end

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Unlock window counts cycles with a bus access after the key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_left <= '0;
    end else if (wr_lane && wr_mapped && wr_idx == IDX_GUARD && wr_byte == GUARD_KEY) begin
      guard_left <= GUARD_WINDOW;
    end else if (guard_left != '0) begin
      guard_left <= guard_left - 3'(wr_fire) - 3'(rd_fire && !wr_fire);
    end
  end

  // Mode control: fuse load at reset, guarded writes after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ctrl.rsvd            <= '0;
      mode_ctrl.sample_rate_sel <= fuse_sync.sample_rate_sel;
      mode_ctrl.active_mode     <= fuse_sync.active_mode;
      mode_ctrl.sleep_mode      <= fuse_sync.sleep_mode;
    end else if (wr_lane && wr_mapped && wr_idx == IDX_MODE_CTRL && guard_open) begin
      mode_ctrl.sample_rate_sel <= wr_byte[4];
      if (wr_byte[1:0] != SLEEP_RESERVED) begin
        mode_ctrl.sleep_mode <= wr_byte[1:0];
      end
    end
  end

  // Threshold code is fuse only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_code <= fuse_sync.threshold_code;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_code <= OFS_5PCT;
    end else if (wr_lane && wr_mapped && wr_idx == IDX_WARN_LEVEL) begin
      ofs_code <= wr_byte[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ctrl <= REG_RESET;
    end else if (wr_lane && wr_mapped && wr_idx == IDX_WARN_IRQ_CTRL) begin
      irq_ctrl.warning_direction_sel <= wr_byte[2:1];
      irq_ctrl.warning_irq_enable    <= wr_byte[0];
    end
  end

  // Below-warning status, held while the detector is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      below_warning_status <= 1'b0;
    end else if (take_sample) begin
      below_warning_status <= below_sync;
    end
  end

  // Sticky flag; a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warning_irq_flag <= 1'b0;
    end else begin
      warning_irq_flag <= (warning_irq_flag && !flag_clear)
                       || (monitor_on && take_sample && warn_event);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= warning_irq_flag && irq_ctrl.warning_irq_enable;
    end
  end

  // Effective mode follows the sleep request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_mode   <= MODE_OFF;
      detector_enable <= 1'b0;
    end else begin
      detector_mode   <= next_mode;
      detector_enable <= (next_mode != MODE_OFF);
    end
  end

  // Sample pulse only while the mode stays sampled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_sample <= 1'b0;
    end else begin
      detector_sample <= (next_mode == MODE_SAMPLED) && tick;
    end
  end

  // Monitor enable drops in the same cycle as the detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_warning_monitor_enable <= 1'b0;
    end else begin
      early_warning_monitor_enable <= (next_mode != MODE_OFF)
                                   && irq_ctrl.warning_irq_enable;
    end
  end

  // Wake-up held off until the detector reports ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_hold <= 1'b0;
    end else begin
      wake_hold <= (mode_ctrl.active_mode == MODE_WAKE_HOLD) && !ready_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_code      <= THR_1V8;
      warning_offset_code <= OFS_5PCT;
      sample_rate_sel     <= 1'b0;
    end else begin
      threshold_code      <= thr_code;
      warning_offset_code <= ofs_code;
      sample_rate_sel     <= mode_ctrl.sample_rate_sel;
    end
  end

endmodule : bmc_monitor

// *** rtl/bmc_pkg.sv ***
// Contract
// - Sample select: 0 gives 1 kHz, 1 gives 125 Hz
// - Sample select loads from fuse, guarded writes
// - Active mode codes: off, on, sampled, wake-hold
// - Active mode read-only, loaded from fuse
// - Low-power mode codes: off, on, sampled, reserved
// - Low-power mode from fuse, writable after unlock
// - Threshold code read-only, loaded from fuse
// - Warning offset 5, 15, 25 percent above
// - Warning direction falling, rising or either
// - Interrupt enable bit gates warning interrupt
// - Flag sets on matching crossing while enabled
// - Status reads one when supply below warning
// - Interrupt high while enable and flag set
// - Warning monitor follows detector mode
// - Low-power mode in sleep, active mode awake
// - Protected write only within four accesses of key; a read and a write in one cycle count as one
package bmc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_MODE_CTRL     = 4'h0;
  localparam logic [3:0] IDX_THRESHOLD     = 4'h1;
  localparam logic [3:0] IDX_RSVD_LO       = 4'h2;
  localparam logic [3:0] IDX_RSVD_HI       = 4'h7;
  localparam logic [3:0] IDX_WARN_LEVEL    = 4'h8;
  localparam logic [3:0] IDX_WARN_IRQ_CTRL = 4'h9;
  localparam logic [3:0] IDX_WARN_FLAGS    = 4'ha;
  localparam logic [3:0] IDX_WARN_STATUS   = 4'hb;
  localparam logic [3:0] IDX_GUARD         = 4'hc;

  localparam int         ADDR_W        = 8;
  localparam int         IDX_LSB       = 2;
  localparam int         IDX_MSB       = 5;
  localparam int         PAGE_LSB      = 6;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] GUARD_KEY     = 8'h5a;
  localparam logic [2:0] GUARD_WINDOW  = 3'h4;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Sample periods
  localparam int CLK_MHZ                = 125;
  localparam int FAST_SAMPLE_PERIOD_US  = 1000;
  localparam int SLOW_SAMPLE_PERIOD_US  = 8000;
  localparam int FAST_SAMPLE_CYCLES_DEF = FAST_SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int SLOW_SAMPLE_CYCLES_DEF = SLOW_SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int SAMPLE_CNT_W           = 20;

  typedef enum logic [1:0] {
    MODE_OFF       = 2'b00,
    MODE_ON        = 2'b01,
    MODE_SAMPLED   = 2'b10,
    MODE_WAKE_HOLD = 2'b11
  } bmc_mode_t;

  typedef enum logic [1:0] {
    DIR_FALL = 2'b00,
    DIR_RISE = 2'b01,
    DIR_BOTH = 2'b10
  } bmc_dir_t;

  localparam logic [1:0] SLEEP_RESERVED = 2'b11;

  // Threshold and offset codes
  localparam logic [2:0] THR_1V8    = 3'h0;
  localparam logic [2:0] THR_2V6    = 3'h2;
  localparam logic [2:0] THR_4V3    = 3'h7;
  localparam logic [1:0] OFS_5PCT   = 2'h0;
  localparam logic [1:0] OFS_15PCT  = 2'h1;
  localparam logic [1:0] OFS_25PCT  = 2'h2;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       sample_rate_sel;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } bmc_mode_ctrl_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [1:0] warning_direction_sel;
    logic       warning_irq_enable;
  } bmc_irq_ctrl_t;

  typedef struct packed {
    logic       sample_rate_sel;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] threshold_code;
  } bmc_fuse_t;

endpackage : bmc_pkg

// *** rtl/bmc_sync.sv ***
`timescale 1ns/10ps
module bmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;

  // Two flops; first stage feeds only the second
  always_ff @(posedge aclk) begin
    stage <= d;
    q     <= stage;
  end

endmodule : bmc_sync

// *** rtl/bmc_sample_ticker.sv ***
`timescale 1ns/10ps
module bmc_sample_ticker
  import bmc_pkg::*;
#(
  parameter int FAST_CYCLES = FAST_SAMPLE_CYCLES_DEF,
  parameter int SLOW_CYCLES = SLOW_SAMPLE_CYCLES_DEF
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic slow,
  output logic      tick
);

  logic [SAMPLE_CNT_W-1:0] count;
  logic [SAMPLE_CNT_W-1:0] last;

  assign last = slow ? SAMPLE_CNT_W'(SLOW_CYCLES - 1) : SAMPLE_CNT_W'(FAST_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= last) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule : bmc_sample_ticker

// *** dv/bmc_monitor_properties.sv ***
`timescale 1ns/10ps
module bmc_monitor_props
  import bmc_pkg::*;
#(
  parameter int FAST_SAMPLE_CYCLES = FAST_SAMPLE_CYCLES_DEF
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire bmc_mode_t         detector_mode,
  input wire logic              detector_enable,
  input wire logic              detector_sample,
  input wire logic              early_warning_monitor_enable,
  input wire logic [2:0]        threshold_code,
  input wire logic              sample_rate_sel
);
  int gap;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since last sample pulse
  always_ff @(posedge aclk) begin
    if (!aresetn)
      gap <= 1000000;
    else if (detector_sample)
      gap <= 0;
    else if (gap < 1000000)
      gap <= gap + 1;
  end

  property p_enable_mode;
    detector_enable == (detector_mode != MODE_OFF);
  endproperty
  a_enable_mode: assert property (p_enable_mode)
    else $error("enable disagrees with mode");
  property p_monitor_follows;
    early_warning_monitor_enable |-> detector_enable;
  endproperty
  a_monitor_follows: assert property (p_monitor_follows)
    else $error("monitor active with detector off");
  property p_sample_mode;
    detector_sample |-> detector_mode == MODE_SAMPLED;
  endproperty
  a_sample_mode: assert property (p_sample_mode)
    else $error("sample pulse outside sampled mode");
  property p_fast_gap;
    detector_sample && !sample_rate_sel |-> gap >= FAST_SAMPLE_CYCLES - 1;
  endproperty
  a_fast_gap: assert property (p_fast_gap)
    else $error("sample pulses too close");
  property p_thr_stable;
    $past(aresetn, 2) |-> $stable(threshold_code);
  endproperty
  a_thr_stable: assert property (p_thr_stable)
    else $error("threshold code changed");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write answer late");
  property p_rsvd_zero;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h08 && s_axi_araddr <= 8'h1c
      |=> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved read not zero");
endmodule : bmc_monitor_props

// *** dv/brownout_monitor_control_tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module brownout_monitor_control_tb;
  import bmc_pkg::*;
  localparam int FAST = 8;
  localparam int SLOW = FAST * 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lpr, below, rdy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, ofs;
  logic        awready, wready, bvalid, arready, rvalid, den, dsmp, mon_en, sel, whold, irq;
  logic [2:0]  thr;
  bmc_fuse_t   fuse;
  bmc_mode_t   mode;
  int          error_cnt, checks, i;

  bmc_monitor #(.FAST_SAMPLE_CYCLES(FAST), .SLOW_SAMPLE_CYCLES(SLOW)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .detector_config_fuse(fuse),
    .low_power_req(lpr), .warn_comp_below(below), .detector_ready(rdy),
    .detector_mode(mode), .detector_enable(den), .detector_sample(dsmp),
    .early_warning_monitor_enable(mon_en), .threshold_code(thr),
    .warning_offset_code(ofs), .sample_rate_sel(sel), .wake_hold(whold), .irq(irq));

  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bready && bvalid === 1'b1) begin
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
        return;
      end
    end
    error_cnt++;
    report_and_stop();
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rready && rvalid === 1'b1) begin
        `CHK("rresp", er, rresp)
        `CHK("rdata", {24'h0, d}, rdata)
        rready <= 1'b0;
        return;
      end
    end
    error_cnt++;
    report_and_stop();
  endtask : axr

  task automatic crossing(input logic [7:0] c, input logic l, input logic f);
    axw(8'h24, c, RESP_OKAY);
    @(posedge aclk);
    below <= l;
    repeat (8) @(posedge aclk);
    axr(8'h28, {7'h0, f}, RESP_OKAY);
    `CHK("irq", f & c[0], irq)
    axw(8'h28, 8'h00, RESP_OKAY);
    axr(8'h28, {7'h0, f}, RESP_OKAY);
    axw(8'h28, 8'h01, RESP_OKAY);
    axr(8'h28, 8'h00, RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    if (c[0]) axr(8'h2c, {7'h0, l}, RESP_OKAY);
  endtask : crossing

  task automatic count_smp(input int exp);
    int c;
    c = 0;
    repeat (40) @(posedge aclk);
    repeat (64) begin
      @(posedge aclk);
      if (dsmp === 1'b1) c++;
    end
    `CHK("samples", exp, c)
  endtask : count_smp

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {error_cnt, checks, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, lpr, below} = '0;
    fuse = 8'h32;
    rdy = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, 8'h06, RESP_OKAY);
    axr(8'h04, 8'h02, RESP_OKAY);
    `CHK("thr", THR_2V6, thr)
    for (i = 8; i < 12; i++) axr(8'(i * 4), 8'h00, RESP_OKAY);
    for (i = 2; i < 8; i++) begin
      axw(8'(i * 4), 8'hff, RESP_OKAY);
      axr(8'(i * 4), 8'h00, RESP_OKAY);
    end
    axw(8'h34, 8'h01, RESP_SLVERR);
    axr(8'h40, 8'h00, RESP_SLVERR);
    axw(8'h00, 8'h1d, RESP_OKAY);
    axr(8'h00, 8'h06, RESP_OKAY);
    axw(8'h30, GUARD_KEY, RESP_OKAY);
    axw(8'h00, 8'h1d, RESP_OKAY);
    axr(8'h00, 8'h15, RESP_OKAY);
    `CHK("sel", 1'b1, sel)
    axw(8'h30, GUARD_KEY, RESP_OKAY);
    repeat (4) axr(8'h04, 8'h02, RESP_OKAY);
    axw(8'h00, 8'h02, RESP_OKAY);
    axr(8'h00, 8'h15, RESP_OKAY);
    axw(8'h30, GUARD_KEY, RESP_OKAY);
    axw(8'h00, 8'h13, RESP_OKAY);
    axr(8'h00, 8'h15, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      axw(8'h20, 8'(i), RESP_OKAY);
      axr(8'h20, 8'(i), RESP_OKAY);
      `CHK("ofs", 2'(i), ofs)
    end
    crossing(8'h01, 1'b1, 1'b1);
    crossing(8'h01, 1'b0, 1'b0);
    crossing(8'h03, 1'b1, 1'b0);
    crossing(8'h03, 1'b0, 1'b1);
    `CHK("mon_en", 1'b1, mon_en)
    crossing(8'h04, 1'b1, 1'b0);
    crossing(8'h04, 1'b0, 1'b0);
    crossing(8'h05, 1'b1, 1'b1);
    crossing(8'h05, 1'b0, 1'b1);
    axw(8'h30, GUARD_KEY, RESP_OKAY);
    axw(8'h00, 8'h10, RESP_OKAY);
    lpr <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("mode", MODE_OFF, mode)
    `CHK("mon_en", 1'b0, mon_en)
    lpr <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("mode", MODE_ON, mode)
    axw(8'h30, GUARD_KEY, RESP_OKAY);
    axw(8'h00, 8'h12, RESP_OKAY);
    lpr <= 1'b1;
    count_smp(64 / SLOW);
    `CHK("mode", MODE_SAMPLED, mode)
    axw(8'h30, GUARD_KEY, RESP_OKAY);
    axw(8'h00, 8'h02, RESP_OKAY);
    count_smp(64 / FAST);
    aresetn <= 1'b0;
    lpr <= 1'b0;
    rdy <= 1'b0;
    fuse <= 8'h6a;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, 8'h0d, RESP_OKAY);
    `CHK("mode", MODE_WAKE_HOLD, mode)
    `CHK("whold", 1'b1, whold)
    rdy <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("whold", 1'b0, whold)
    report_and_stop();
  end
endmodule : brownout_monitor_control_tb

bind bmc_monitor bmc_monitor_props #(.FAST_SAMPLE_CYCLES(FAST_SAMPLE_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .detector_mode(detector_mode),
  .detector_enable(detector_enable), .detector_sample(detector_sample),
  .early_warning_monitor_enable(early_warning_monitor_enable),
  .threshold_code(threshold_code), .sample_rate_sel(sample_rate_sel));
